// *** pfsel_latch.sv ***
// Fault status register and Error-state latch of a USB port power switch.
// Assumes register strobes from a management-port engine on SYS_CLK and
// comparator levels arriving asynchronously from the analogue section.
`timescale 1ns/10ps
`include "pfsel_consts.svh"

module pfsel_latch (
	// Clock and reset
	input  wire logic                SYS_CLK,
	input  wire logic                RST_N,
	// Register access from the management port
	input  wire pfsel_pkg::pfsel_req_t REG_REQ,
	output logic [7:0]               REG_RDATA,
	// Analogue comparator levels, asynchronous
	input  wire pfsel_pkg::pfsel_cond_t FAULT_COND,
	// Configuration levels on SYS_CLK
	input  wire logic                PORT_POWER_ENABLE,
	input  wire logic                AUTO_RECOVERY,
	// Open-drain host alert pin
	output logic                     ALERT_N_O,
	output logic                     ALERT_N_OE_N,
	// Device state
	output logic                     ERROR_STATE
);

	// ****************************************
	// Comparator synchronisers
	// ****************************************
	pfsel_pkg::pfsel_cond_t cond_meta_reg;
	pfsel_pkg::pfsel_cond_t cond_reg;
	logic [5:0]             cond;
	logic [5:0]             flags_reg;
	logic [5:0]             flags_next;
	logic                   err_reg;
	logic                   err_next;
	logic                   por_reg;
	logic                   ppe_reg;
	logic                   rd_fault;
	logic                   wr_fault;
	logic                   host_err_clr;
	logic                   auto_err_clr;
	logic                   err_clr;
	logic                   any_cond;
	logic [5:0]             flag_clr;
	logic [7:0]             fault_byte;
	logic [7:0]             misc_byte;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			cond_meta_reg <= '0;
			cond_reg      <= '0;
		end else begin
			cond_meta_reg <= FAULT_COND;
			cond_reg      <= cond_meta_reg;
		end
	end

	assign cond     = cond_reg;
	assign any_cond = |cond;

	// ****************************************
	// Access decode and clear events
	// ****************************************
	assign rd_fault = REG_REQ.rd && (REG_REQ.addr == `PFSEL_FAULT_STATUS_OFS);
	assign wr_fault = REG_REQ.wr && (REG_REQ.addr == `PFSEL_FAULT_STATUS_OFS);
	// Writing one to the error bit is ignored: only hardware sets it
	assign host_err_clr = wr_fault && !REG_REQ.wdata[`PFSEL_ERR_BIT];
	// Auto-recovery waits until the host has read out every flag
	assign auto_err_clr = AUTO_RECOVERY && !any_cond && (flags_reg == 6'h00);
	assign err_clr      = host_err_clr || auto_err_clr || !PORT_POWER_ENABLE;

	// Read or error clear drops a flag only once its fault is gone
	assign flag_clr = (rd_fault || (err_clr && err_reg)) ? ~cond : 6'h00;

	// ****************************************
	// Sticky fault flags
	// ****************************************
	// A live fault wins over any clear in the same cycle
	assign flags_next = cond | (flags_reg & ~flag_clr);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			flags_reg <= `PFSEL_FLAGS_RST;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// ****************************************
	// Error state and error flag
	// ****************************************
	// Leaving needs a clear event, no fault present, and no flag left set
	always_comb begin
		err_next = err_reg;
		if (|flags_next) begin
			err_next = 1'b1;
		end else if (err_clr && !any_cond) begin
			err_next = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			err_reg <= `PFSEL_ERR_RST;
		end else begin
			err_reg <= err_next;
		end
	end

	// ****************************************
	// Power-on indicator
	// ****************************************
	// No sleep logic here: the bit simply holds until read or toggle
	// No reset: tracking the pin through reset keeps release from reading as a toggle
	always_ff @(posedge SYS_CLK) begin
		ppe_reg <= PORT_POWER_ENABLE;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			por_reg <= `PFSEL_POR_RST;
		end else if (rd_fault || (ppe_reg != PORT_POWER_ENABLE)) begin
			por_reg <= 1'b0;
		end
	end

	// ****************************************
	// Alert pin
	// ****************************************
	// Driven from flags only, so it can drop while error still stands
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ALERT_N_OE_N <= 1'b1;
		end else begin
			ALERT_N_OE_N <= ~(|flags_next);
		end
	end

	assign ALERT_N_O   = 1'b0;
	assign ERROR_STATE = err_reg;

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		fault_byte = 8'h00;
		fault_byte[`PFSEL_ERR_BIT]   = err_reg;
		fault_byte[`PFSEL_DISCH_BIT] = flags_reg[5];
		fault_byte[`PFSEL_POR_BIT]   = por_reg;
		fault_byte[`PFSEL_UNDER_BIT] = flags_reg[4];
		fault_byte[`PFSEL_THERM_BIT] = flags_reg[3];
		fault_byte[`PFSEL_SRCOV_BIT] = flags_reg[2];
		fault_byte[`PFSEL_BACKV_BIT] = flags_reg[1];
		fault_byte[`PFSEL_OVERC_BIT] = flags_reg[0];
		misc_byte = 8'h00;
		misc_byte[`PFSEL_ALERT_PIN_BIT] = ~ALERT_N_OE_N;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			REG_RDATA <= `PFSEL_RDATA_RST;
		end else if (REG_REQ.rd) begin
			case (REG_REQ.addr)
				`PFSEL_FAULT_STATUS_OFS: begin
					REG_RDATA <= fault_byte;
				end
				`PFSEL_MISC_STATUS_OFS: begin
					REG_RDATA <= misc_byte;
				end
				default: begin
					REG_RDATA <= 8'h00;
				end
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	chk_err_follows_flag: assert property (|flags_reg |-> err_reg)
		else $error("Error flag low while a fault flag is set");

	chk_err_exit_guard: assert property ($fell(err_reg) |-> $past(err_clr) && !$past(any_cond))
		else $error("Error state left without clear or with fault present");

	// A host clear may drop flags and error together, never error alone
	chk_err_hold: assert property (err_reg && (|flags_reg) |=> err_reg || flags_reg == 6'h00)
		else $error("Error state left while a flag was set");

	chk_ppe_clear: assert property (err_reg && !PORT_POWER_ENABLE && !any_cond |=> !err_reg)
		else $error("Error flag not cleared by power enable low");

	chk_disch_set: assert property (cond[5] |=> flags_reg[5] && err_reg && !ALERT_N_OE_N)
		else $error("Discharge fault not latched with alert");

	chk_flag_sticky: assert property (flags_reg != 6'h00 && !rd_fault && !err_clr
		|=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
		else $error("Fault flag dropped without a clear event");

	chk_read_keeps_live: assert property (rd_fault && cond[0] |=> flags_reg[0])
		else $error("Overcurrent flag cleared while condition present");

	chk_por_clear: assert property (por_reg && rd_fault |=> !por_reg)
		else $error("Power-on indicator survived a read");

	chk_por_no_alert: assert property (flags_reg == 6'h00 && cond == 6'h00 |=> ALERT_N_OE_N)
		else $error("Alert raised with no fault flag");

	chk_alert_or: assert property (ALERT_N_OE_N == ~(|flags_reg))
		else $error("Alert pin does not match fault flags");

	chk_thermal_path: assert property ($rose(FAULT_COND.therm) ##2 1 |=> flags_reg[3])
		else $error("Thermal flag not set three cycles after condition");

	// ****************************************
	// Error state checks
	// ****************************************
	chk_host_clr_live: assert property (err_reg && host_err_clr && any_cond |=> err_reg)
		else $error("Error state left by host clear while a fault was present");

	chk_host_clr_exit: assert property (err_reg && host_err_clr && !any_cond |=> !err_reg)
		else $error("Error state kept after host clear with no fault");

	chk_err_write_one: assert property (err_reg && wr_fault && REG_REQ.wdata[`PFSEL_ERR_BIT]
		&& !AUTO_RECOVERY && PORT_POWER_ENABLE |=> err_reg)
		else $error("Writing one to the error flag cleared it");

	chk_auto_exit: assert property (err_reg && AUTO_RECOVERY && !any_cond
		&& flags_reg == 6'h00 |=> !err_reg)
		else $error("Auto-recovery did not clear the error flag");

	// Auto-recovery must not skip the read of a set flag
	chk_auto_wait_read: assert property (AUTO_RECOVERY && PORT_POWER_ENABLE && err_reg && (|flags_reg)
		&& !host_err_clr |=> err_reg)
		else $error("Auto-recovery left Error state with a flag set");

	// ****************************************
	// Fault flag checks
	// ****************************************
	chk_under_set: assert property (cond[4] |=> flags_reg[4] && err_reg && !ALERT_N_OE_N)
		else $error("Undervoltage fault not latched with alert");

	chk_therm_set: assert property (cond[3] |=> flags_reg[3] && err_reg && !ALERT_N_OE_N)
		else $error("Thermal fault not latched with alert");

	chk_srcov_set: assert property (cond[2] |=> flags_reg[2] && err_reg && !ALERT_N_OE_N)
		else $error("Source overvoltage fault not latched with alert");

	chk_backv_set: assert property (cond[1] |=> flags_reg[1] && err_reg && !ALERT_N_OE_N)
		else $error("Back-voltage fault not latched with alert");

	chk_overc_set: assert property (cond[0] |=> flags_reg[0] && err_reg && !ALERT_N_OE_N)
		else $error("Overcurrent fault not latched with alert");

	chk_read_clears_gone: assert property (rd_fault |=> flags_reg == $past(cond))
		else $error("Read left a flag of a gone fault or dropped a live one");

	chk_ppe_low_flags: assert property (!PORT_POWER_ENABLE && err_reg |=> flags_reg == $past(cond))
		else $error("Error clear by power enable left a stale flag");

	chk_overc_read_clear: assert property (rd_fault && !cond[0] |=> !flags_reg[0])
		else $error("Overcurrent flag survived a read after the fault ended");

	// ****************************************
	// Power-on and read checks
	// ****************************************
	chk_por_toggle: assert property (por_reg && $changed(PORT_POWER_ENABLE) |=> !por_reg)
		else $error("Power-on indicator survived a power enable toggle");

	chk_por_no_reset: assert property (!por_reg |=> !por_reg)
		else $error("Power-on indicator set outside reset");

	chk_misc_alert: assert property (REG_REQ.rd && REG_REQ.addr == `PFSEL_MISC_STATUS_OFS
		|=> REG_RDATA[`PFSEL_ALERT_PIN_BIT] == !$past(ALERT_N_OE_N))
		else $error("Misc status alert bit does not match the alert pin");

	// ****************************************
	// Cover points
	// ****************************************
	cov_fault_latched: cover property (cond != 6'h00 ##1 err_reg);
	cov_host_recover: cover property (err_reg && host_err_clr && !any_cond ##1 !err_reg);
	cov_auto_recover: cover property (err_reg && auto_err_clr ##1 !err_reg);
	cov_alert_off_err_on: cover property (ALERT_N_OE_N && err_reg);
	cov_por_toggle: cover property (por_reg && $changed(PORT_POWER_ENABLE) ##1 !por_reg);

endmodule

// *** pfsel_consts.svh ***
// Offsets, field positions and reset values of the port fault status latch.
// Assumes inclusion by bare name from the design module.
`ifndef PFSEL_CONSTS_SVH
`define PFSEL_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PFSEL_MISC_STATUS_OFS   8'h0F
`define PFSEL_FAULT_STATUS_OFS  8'h10

// ****************************************
// Fault status field positions
// ****************************************
`define PFSEL_ERR_BIT           3'h7
`define PFSEL_DISCH_BIT         3'h6
`define PFSEL_POR_BIT           3'h5
`define PFSEL_UNDER_BIT         3'h4
`define PFSEL_THERM_BIT         3'h3
`define PFSEL_SRCOV_BIT         3'h2
`define PFSEL_BACKV_BIT         3'h1
`define PFSEL_OVERC_BIT         3'h0

// ****************************************
// Misc status field positions
// ****************************************
`define PFSEL_ALERT_PIN_BIT     3'h5

// ****************************************
// Reset values
// ****************************************
`define PFSEL_FLAGS_RST         6'h00
`define PFSEL_ERR_RST           1'h0
`define PFSEL_POR_RST           1'h1
`define PFSEL_RDATA_RST         8'h00

`endif

// *** pfsel_pkg.sv ***
// Types shared by the port fault status latch.
// Assumes nothing beyond the constants header.
package pfsel_pkg;

	// Comparator results, one per alert-raising fault
	typedef struct packed {
		logic disch;
		logic under;
		logic therm;
		logic srcov;
		logic backv;
		logic overc;
	} pfsel_cond_t;

	// Register access strobes from the management port engine
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pfsel_req_t;

endpackage

// *** pfsel_host.sv ***
// Host model issuing register strobes to the port fault status latch.
// Assumes the same clock as the latch and one request at a time.
`timescale 1ns/10ps
module pfsel_host (
	// Clock
	input  wire logic             clk,
	// Register port
	output pfsel_pkg::pfsel_req_t req,
	input  wire logic [7:0]       rdata
);
	initial req = '0;

	// Data is taken just after the edge that accepts the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1 d = rdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(posedge clk);
		req <= '0;
	endtask
endmodule

// *** port_fault_status_error_latch_tb.sv ***
// Self-checking bench for the port fault status latch.
// Assumes the host model and the latch share one 40 MHz clock.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", nm, e, a); end end
module port_fault_status_error_latch_tb;
	logic                   sys_clk, rst_n, port_power_enable, auto_rec, alert_o, alert_oe_n, err;
	pfsel_pkg::pfsel_req_t  req;
	pfsel_pkg::pfsel_cond_t cond;
	logic [7:0]             rdata, d;
	int                     n_mismatch, checks, cycles;
	// Pull-up on the open-drain alert line
	wire alert_n = alert_oe_n ? 1'b1 : alert_o;

	pfsel_latch DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
		.FAULT_COND(cond), .PORT_POWER_ENABLE(port_power_enable), .AUTO_RECOVERY(auto_rec),
		.ALERT_N_O(alert_o), .ALERT_N_OE_N(alert_oe_n), .ERROR_STATE(err));
	pfsel_host host (.clk(sys_clk), .req(req), .rdata(rdata));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		`CHK("err", 1'b0, err)
		`CHK("alert", 1'b1, alert_n)
		host.rd(8'h10, d);
		`CHK("por", 8'h20, d)
		host.rd(8'h10, d);
		`CHK("por clr", 8'h00, d)
		host.rd(8'h0F, d);
		`CHK("misc", 8'h00, d)
		host.rd(8'h33, d);
		`CHK("unmapped", 8'h00, d)
	endtask

	task automatic t_fault(input int i);
		logic [7:0] m;
		m = (i == 5) ? 8'h40 : (8'h01 << i);
		@(posedge sys_clk);
		cond <= 6'h01 << i;
		wait_cyc(4);
		`CHK("err set", 1'b1, err)
		`CHK("alert set", 1'b0, alert_n)
		host.rd(8'h0F, d);
		`CHK("misc alert", 8'h20, d)
		host.wr(8'h10, 8'h00);
		wait_cyc(1);
		`CHK("err held", 1'b1, err)
		host.rd(8'h10, d);
		`CHK("flags", 8'h80 | m, d)
		`CHK("alert live", 1'b0, alert_n)
		@(posedge sys_clk);
		cond <= '0;
		wait_cyc(4);
		host.rd(8'h10, d);
		`CHK("flags kept", 8'h80 | m, d)
		`CHK("alert free", 1'b1, alert_n)
		`CHK("err stays", 1'b1, err)
		host.wr(8'h10, 8'h00);
		wait_cyc(1);
		`CHK("err clr", 1'b0, err)
	endtask

	task automatic t_auto;
		@(posedge sys_clk);
		auto_rec <= 1'b1;
		cond <= 6'h01;
		wait_cyc(4);
		@(posedge sys_clk);
		cond <= '0;
		wait_cyc(5);
		`CHK("auto held", 1'b1, err)
		host.rd(8'h10, d);
		`CHK("auto flags", 8'h81, d)
		wait_cyc(2);
		`CHK("auto clr", 1'b0, err)
		@(posedge sys_clk);
		auto_rec <= 1'b0;
	endtask

	task automatic t_pwr;
		@(posedge sys_clk);
		cond <= 6'h08;
		wait_cyc(4);
		@(posedge sys_clk);
		cond <= '0;
		wait_cyc(3);
		@(posedge sys_clk);
		port_power_enable <= 1'b0;
		wait_cyc(2);
		`CHK("pwr clr", 1'b0, err)
		host.rd(8'h10, d);
		`CHK("pwr flags", 8'h00, d)
		@(posedge sys_clk);
		port_power_enable <= 1'b1;
	endtask

	// Mid-run reset: power-on bit returns, a toggle clears it
	task automatic t_rst_mid;
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		wait_cyc(1);
		`CHK("rst err", 1'b0, err)
		`CHK("rst alert", 1'b1, alert_n)
		@(posedge sys_clk);
		port_power_enable <= 1'b0;
		@(posedge sys_clk);
		port_power_enable <= 1'b1;
		wait_cyc(2);
		host.rd(8'h10, d);
		`CHK("por toggle", 8'h00, d)
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		wait_cyc(1);
		host.rd(8'h10, d);
		`CHK("por again", 8'h20, d)
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		rst_n = 1'b0;
		port_power_enable = 1'b1;
		auto_rec = 1'b0;
		cond = '0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		wait_cyc(1);
		t_reset();
		for (int i = 0; i < 6; i++) begin
			t_fault(i);
		end
		t_auto();
		t_pwr();
		t_rst_mid();
		tally_and_finish();
	end
endmodule
